// File: ierc_params.svh
`ifndef IERC_PARAMS_SVH
`define IERC_PARAMS_SVH
// Register byte offsets
`define IERC_OFF_EN 12'h000
`define IERC_OFF_RQ 12'h004
`define IERC_OFF_EDGE 12'h008
`define IERC_OFF_SP 12'h00c
`define IERC_OFF_STAT 12'h010
// Reset values
`define IERC_RST_EN 6'h00
`define IERC_RST_RQ 6'h00
`define IERC_RST_EDGE 12'h000
`define IERC_RST_SP 8'h00
// Entry vector
`define IERC_VECTOR 16'h0010
// Stack step in bytes
`define IERC_SP_STEP 8'h02
// Line count
`define IERC_LINES 6
`endif

// File: ierc_pkg.sv
package ierc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PUSH_LO = 6'h02,
    ST_PUSH_HI = 6'h04,
    ST_POP_LO = 6'h08,
    ST_POP_HI = 6'h10,
    ST_DONE = 6'h20
  } ierc_state_t;
  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_NONE = 2'h3
  } ierc_edge_t;
endpackage : ierc_pkg

// File: ierc_stack_ram.sv
`timescale 1ns/10ps
`default_nettype none
module ierc_stack_ram #(
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule : ierc_stack_ram
`default_nettype wire

// File: ierc_top.sv
// How it works
// - Six request lines, pins timers comparator pwm
// - Each line has its own enable bit
// - Hardware sets flags, software writes to clear
// - Flag set on rising, falling or both
// - Global enable set/cleared by core instructions
// - Entry pushes program counter at stack pointer
// - Entry advances stack pointer by two
// - Entry clears global enable
// - Entry fetch comes from vector 0x010
// - Flags set even when line disabled
// - Return pops program counter from stack
// - Return lowers stack pointer by two
// - Return sets global enable again
// - Resume at the interrupted instruction
// - Push/pop accumulator and flags pair
// - Reading flags returns all pending sources
// - Writing zero clears only that flag
`timescale 1ns/10ps
`default_nettype none
`include "ierc_params.svh"
module ierc_top #(
  parameter int NL = `IERC_LINES
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // AXI4-Lite
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Sources: [0] port_a_line_zero, [1] port_a_line_four, [2] sixteen_bit_timer,
  // [3] comparator_unit, [4] led_pwm_generator_set, [5] eight_bit_timer
  input wire logic [NL-1:0] IRQ_SRC_I,
  // Core sequencer
  input wire logic BOUNDARY_I,
  input wire logic [15:0] PC_I,
  input wire logic ENGINT_I,
  input wire logic DISGINT_I,
  input wire logic RETI_I,
  input wire logic PUSHAF_I,
  input wire logic POPAF_I,
  input wire logic [7:0] ACC_I,
  input wire logic [7:0] FLAGS_I,
  output logic BUSY_O,
  output logic TAKE_O,
  output logic LOAD_PC_O,
  output logic [15:0] NEW_PC_O,
  output logic RESTORE_AF_O,
  output logic [7:0] ACC_O,
  output logic [7:0] FLAGS_O,
  output logic GIE_O
);
  logic [NL-1:0] s1_reg, s2_reg, s3_reg, seen_reg, hit;
  logic [NL-1:0] en_reg, rq_reg;
  logic [2*NL-1:0] edge_reg;
  logic [7:0] sp_reg;
  logic gie_reg;
  ierc_pkg::ierc_state_t st_reg;
  logic is_af_reg, is_ret_reg, pop_af_reg;
  logic [7:0] lo_reg;
  logic we;
  logic [7:0] ram_addr, ram_wdata, ram_rdata;
  logic aw_got_reg, w_got_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wr_fire, rq_wr;
  logic [NL-1:0] rq_clear;
  logic take;

  // Input synchronisers, change counts when 2nd and 3rd agree
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      seen_reg <= '0;
    end else begin
      s1_reg <= IRQ_SRC_I;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NL; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          seen_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_edge
      logic agree, rise, fall;
      assign agree = (s2_reg[g] == s3_reg[g]);
      assign rise = agree && s3_reg[g] && !seen_reg[g];
      assign fall = agree && !s3_reg[g] && seen_reg[g];
      always_comb begin
        case (ierc_pkg::ierc_edge_t'(edge_reg[2*g+:2]))
          ierc_pkg::EDGE_RISE: hit[g] = rise;
          ierc_pkg::EDGE_FALL: hit[g] = fall;
          ierc_pkg::EDGE_BOTH: hit[g] = rise | fall;
          default: hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // AXI write path
  assign S_AXI_AWREADY_O = !aw_got_reg && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_got_reg && !S_AXI_BVALID_O;
  assign wr_fire = aw_got_reg && w_got_reg && !S_AXI_BVALID_O;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_got_reg <= 1'b1;
        wdata_reg <= S_AXI_WSTRB_I[0] ? S_AXI_WDATA_I : 32'hffffffff;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        case (awaddr_reg)
          `IERC_OFF_EN, `IERC_OFF_RQ, `IERC_OFF_EDGE, `IERC_OFF_SP: S_AXI_BRESP_O <= 2'h0;
          `IERC_OFF_STAT: S_AXI_BRESP_O <= 2'h0;
          default: S_AXI_BRESP_O <= 2'h2;
        endcase
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end
  assign rq_wr = wr_fire && (awaddr_reg == `IERC_OFF_RQ);
  assign rq_clear = rq_wr ? ~wdata_reg[NL-1:0] : '0;

  // Config registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      en_reg <= `IERC_RST_EN;
      edge_reg <= `IERC_RST_EDGE;
    end else if (wr_fire) begin
      if (awaddr_reg == `IERC_OFF_EN) begin
        en_reg <= wdata_reg[NL-1:0];
      end
      if (awaddr_reg == `IERC_OFF_EDGE) begin
        edge_reg <= wdata_reg[2*NL-1:0];
      end
    end
  end

  // Request flags: set wins over clear, set regardless of enable
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rq_reg <= `IERC_RST_RQ;
    end else begin
      rq_reg <= (rq_reg & ~rq_clear) | hit;
    end
  end

  // AXI read path
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= 2'h0;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= 2'h0;
      case (S_AXI_ARADDR_I)
        `IERC_OFF_EN: S_AXI_RDATA_O <= {{(32-NL){1'b0}}, en_reg};
        `IERC_OFF_RQ: S_AXI_RDATA_O <= {{(32-NL){1'b0}}, rq_reg};
        `IERC_OFF_EDGE: S_AXI_RDATA_O <= {{(32-2*NL){1'b0}}, edge_reg};
        `IERC_OFF_SP: S_AXI_RDATA_O <= {24'h000000, sp_reg};
        `IERC_OFF_STAT: S_AXI_RDATA_O <= {26'h0000000, st_reg};
        default: begin
          S_AXI_RDATA_O <= 32'h00000000;
          S_AXI_RRESP_O <= 2'h2;
        end
      endcase
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  // Entry condition
  assign take = (st_reg == ierc_pkg::ST_IDLE) && BOUNDARY_I && gie_reg
                && |(rq_reg & en_reg);

  // Global enable
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      gie_reg <= 1'b0;
    end else if (take) begin
      gie_reg <= 1'b0;
    end else if (st_reg == ierc_pkg::ST_POP_HI && is_ret_reg) begin
      gie_reg <= 1'b1;
    end else if (st_reg == ierc_pkg::ST_IDLE && ENGINT_I) begin
      gie_reg <= 1'b1;
    end else if (st_reg == ierc_pkg::ST_IDLE && DISGINT_I) begin
      gie_reg <= 1'b0;
    end
  end

  // Sequencer: push lo byte at sp, hi at sp+1; pop from sp-2
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_reg <= ierc_pkg::ST_IDLE;
      is_af_reg <= 1'b0;
      is_ret_reg <= 1'b0;
      lo_reg <= 8'h00;
    end else begin
      case (st_reg)
        ierc_pkg::ST_IDLE: begin
          if (take) begin
            st_reg <= ierc_pkg::ST_PUSH_LO;
            is_af_reg <= 1'b0;
          end else if (RETI_I) begin
            st_reg <= ierc_pkg::ST_POP_LO;
            is_af_reg <= 1'b0;
            is_ret_reg <= 1'b1;
          end else if (PUSHAF_I) begin
            st_reg <= ierc_pkg::ST_PUSH_LO;
            is_af_reg <= 1'b1;
          end else if (POPAF_I) begin
            st_reg <= ierc_pkg::ST_POP_LO;
            is_af_reg <= 1'b1;
            is_ret_reg <= 1'b0;
          end
        end
        ierc_pkg::ST_PUSH_LO: st_reg <= ierc_pkg::ST_PUSH_HI;
        ierc_pkg::ST_PUSH_HI: st_reg <= ierc_pkg::ST_DONE;
        ierc_pkg::ST_POP_LO: st_reg <= ierc_pkg::ST_POP_HI;
        ierc_pkg::ST_POP_HI: begin
          lo_reg <= ram_rdata;
          st_reg <= ierc_pkg::ST_DONE;
        end
        ierc_pkg::ST_DONE: begin
          is_ret_reg <= 1'b0;
          st_reg <= ierc_pkg::ST_IDLE;
        end
        default: st_reg <= ierc_pkg::ST_IDLE;
      endcase
    end
  end

  // Stack pointer (register writes force bit 0 clear)
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sp_reg <= `IERC_RST_SP;
    end else if (st_reg == ierc_pkg::ST_PUSH_HI) begin
      sp_reg <= sp_reg + `IERC_SP_STEP;
    end else if (st_reg == ierc_pkg::ST_POP_HI) begin
      sp_reg <= sp_reg - `IERC_SP_STEP;
    end else if (wr_fire && awaddr_reg == `IERC_OFF_SP) begin
      sp_reg <= {wdata_reg[7:1], 1'b0};
    end
  end

  // Stack memory port
  logic [15:0] pc_hold_reg;
  logic [7:0] acc_hold_reg, flg_hold_reg;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pc_hold_reg <= 16'h0000;
      acc_hold_reg <= 8'h00;
      flg_hold_reg <= 8'h00;
    end else if (st_reg == ierc_pkg::ST_IDLE) begin
      pc_hold_reg <= PC_I;
      acc_hold_reg <= ACC_I;
      flg_hold_reg <= FLAGS_I;
    end
  end
  always_comb begin
    we = 1'b0;
    ram_addr = sp_reg;
    ram_wdata = 8'h00;
    case (st_reg)
      ierc_pkg::ST_PUSH_LO: begin
        we = 1'b1;
        ram_wdata = is_af_reg ? acc_hold_reg : pc_hold_reg[7:0];
      end
      ierc_pkg::ST_PUSH_HI: begin
        we = 1'b1;
        ram_addr = sp_reg + 8'h01;
        ram_wdata = is_af_reg ? flg_hold_reg : pc_hold_reg[15:8];
      end
      ierc_pkg::ST_POP_LO: ram_addr = sp_reg - `IERC_SP_STEP;
      ierc_pkg::ST_POP_HI: ram_addr = sp_reg - 8'h01;
      default: ram_addr = sp_reg;
    endcase
  end

  ierc_stack_ram #(
    .AW(8)
  ) u_ram (
    .clk_i(CLK_I),
    .we_i(we),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // Core-facing outputs
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LOAD_PC_O <= 1'b0;
      NEW_PC_O <= 16'h0000;
      RESTORE_AF_O <= 1'b0;
      ACC_O <= 8'h00;
      FLAGS_O <= 8'h00;
    end else begin
      LOAD_PC_O <= 1'b0;
      RESTORE_AF_O <= 1'b0;
      if (st_reg == ierc_pkg::ST_PUSH_HI && !is_af_reg) begin
        LOAD_PC_O <= 1'b1;
        NEW_PC_O <= `IERC_VECTOR;
      end
      if (st_reg == ierc_pkg::ST_DONE && is_ret_reg) begin
        LOAD_PC_O <= 1'b1;
        NEW_PC_O <= {ram_rdata, lo_reg};
      end
      if (st_reg == ierc_pkg::ST_DONE && is_af_reg && !is_ret_reg && pop_af_reg) begin
        RESTORE_AF_O <= 1'b1;
        ACC_O <= lo_reg;
        FLAGS_O <= ram_rdata;
      end
    end
  end
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pop_af_reg <= 1'b0;
    end else if (st_reg == ierc_pkg::ST_POP_LO) begin
      pop_af_reg <= 1'b1;
    end else if (st_reg == ierc_pkg::ST_IDLE) begin
      pop_af_reg <= 1'b0;
    end
  end

  assign BUSY_O = (st_reg != ierc_pkg::ST_IDLE);
  assign TAKE_O = take;
  assign GIE_O = gie_reg;
endmodule : ierc_top
`default_nettype wire

// File: ierc_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ierc_checker (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic BOUNDARY_I,
  input wire logic ENGINT_I,
  input wire logic DISGINT_I,
  input wire logic RETI_I,
  input wire logic PUSHAF_I,
  input wire logic POPAF_I,
  input wire logic BUSY_O,
  input wire logic TAKE_O,
  input wire logic LOAD_PC_O,
  input wire logic [15:0] NEW_PC_O,
  input wire logic RESTORE_AF_O,
  input wire logic GIE_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  property p_take;
    TAKE_O |-> BOUNDARY_I && GIE_O && !BUSY_O;
  endproperty
  a_take: assert property (p_take) else $error("take without cause");
  property p_gie_off;
    TAKE_O |=> !GIE_O;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("enable kept on entry");
  property p_vector;
    TAKE_O |-> ##3 LOAD_PC_O && NEW_PC_O == 16'h0010;
  endproperty
  a_vector: assert property (p_vector) else $error("bad entry fetch");
  property p_entry;
    TAKE_O |=> BUSY_O [*2] ##[1:3] !BUSY_O;
  endproperty
  a_entry: assert property (p_entry) else $error("bad entry length");
  property p_ret_gie;
    RETI_I && !BUSY_O && !TAKE_O |-> ##3 GIE_O;
  endproperty
  a_ret_gie: assert property (p_ret_gie) else $error("enable not restored");
  property p_ret_load;
    RETI_I && !BUSY_O && !TAKE_O |-> ##4 LOAD_PC_O;
  endproperty
  a_ret_load: assert property (p_ret_load) else $error("no return load");
  property p_pop;
    POPAF_I && !BUSY_O && !TAKE_O && !RETI_I && !PUSHAF_I |-> ##4 RESTORE_AF_O && !LOAD_PC_O;
  endproperty
  a_pop: assert property (p_pop) else $error("no restore");
  property p_eng;
    ENGINT_I && !DISGINT_I && !BUSY_O && !TAKE_O |=> GIE_O;
  endproperty
  a_eng: assert property (p_eng) else $error("enable not set");
  property p_dis;
    DISGINT_I && !ENGINT_I && !BUSY_O |=> !GIE_O;
  endproperty
  a_dis: assert property (p_dis) else $error("enable not cleared");
  c_take: cover property (TAKE_O);
  c_pop: cover property (RESTORE_AF_O);
  c_ret: cover property (RETI_I && !BUSY_O ##4 LOAD_PC_O);
endmodule : ierc_checker
bind ierc_top ierc_checker u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
  .BOUNDARY_I(BOUNDARY_I), .ENGINT_I(ENGINT_I), .DISGINT_I(DISGINT_I), .RETI_I(RETI_I),
  .PUSHAF_I(PUSHAF_I), .POPAF_I(POPAF_I), .BUSY_O(BUSY_O), .TAKE_O(TAKE_O),
  .LOAD_PC_O(LOAD_PC_O), .NEW_PC_O(NEW_PC_O), .RESTORE_AF_O(RESTORE_AF_O),
  .GIE_O(GIE_O));
`default_nettype wire

// File: ierc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module ierc_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic busy_i,
  input wire logic load_pc_i,
  input wire logic [15:0] new_pc_i,
  input wire logic stall_i,
  output logic [15:0] pc_o,
  output logic boundary_o
);
  // Next instruction address, held while stalled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o <= 16'h0100;
    end else if (load_pc_i) begin
      pc_o <= new_pc_i;
    end else if (!busy_i && !stall_i) begin
      pc_o <= pc_o + 16'h0001;
    end
  end
  assign boundary_o = !busy_i && !stall_i;
endmodule : ierc_core_model
`default_nettype wire

// File: ierc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ierc_params.svh"
module ierc_top_tb;
  logic CLK_I, RESET_N_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O;
  logic S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic S_AXI_RREADY_I, BOUNDARY_I, ENGINT_I, DISGINT_I, RETI_I, PUSHAF_I, POPAF_I, BUSY_O;
  logic TAKE_O, LOAD_PC_O, RESTORE_AF_O, GIE_O, stall;
  logic [11:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O, q;
  logic [3:0] S_AXI_WSTRB_I;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, rsp;
  logic [5:0] IRQ_SRC_I, ex;
  logic [15:0] PC_I, NEW_PC_O, saved_pc, rv;
  logic [15:0] st_lf = 16'h0e81;
  logic [7:0] ACC_I, FLAGS_I, ACC_O, FLAGS_O, sp;
  int errors, n_tests, k, j;
  int takes = 0;
  ierc_top dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_WSTRB_I(S_AXI_WSTRB_I),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .IRQ_SRC_I(IRQ_SRC_I), .BOUNDARY_I(BOUNDARY_I), .PC_I(PC_I), .ENGINT_I(ENGINT_I),
    .DISGINT_I(DISGINT_I), .RETI_I(RETI_I), .PUSHAF_I(PUSHAF_I), .POPAF_I(POPAF_I),
    .ACC_I(ACC_I), .FLAGS_I(FLAGS_I), .BUSY_O(BUSY_O), .TAKE_O(TAKE_O),
    .LOAD_PC_O(LOAD_PC_O), .NEW_PC_O(NEW_PC_O), .RESTORE_AF_O(RESTORE_AF_O),
    .ACC_O(ACC_O), .FLAGS_O(FLAGS_O), .GIE_O(GIE_O));
  ierc_core_model core (.clk_i(CLK_I), .rst_n_i(RESET_N_I), .busy_i(BUSY_O),
    .load_pc_i(LOAD_PC_O), .new_pc_i(NEW_PC_O), .stall_i(stall), .pc_o(PC_I),
    .boundary_o(BOUNDARY_I));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  function automatic logic exp_edge(input int m, input logic r);
    return m == ierc_pkg::EDGE_BOTH || m == (r ? ierc_pkg::EDGE_RISE : ierc_pkg::EDGE_FALL);
  endfunction : exp_edge
  task print_verdict;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task tmo;
    errors++;
    print_verdict();
  endtask : tmo
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic aw, wd, ar, dn;
    int n;
    aw = w;
    wd = w;
    ar = !w;
    dn = 0;
    n = 0;
    @(posedge CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_ARADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= w;
    S_AXI_WVALID_I <= w;
    S_AXI_ARVALID_I <= !w;
    S_AXI_BREADY_I <= w;
    S_AXI_RREADY_I <= !w;
    while (!dn) begin
      @(negedge CLK_I);
      if (S_AXI_AWREADY_O === 1'b1) aw = 0;
      if (S_AXI_WREADY_O === 1'b1) wd = 0;
      if (S_AXI_ARREADY_O === 1'b1) ar = 0;
      dn = (w ? S_AXI_BVALID_O : S_AXI_RVALID_O) === 1'b1;
      q = S_AXI_RDATA_O;
      rsp = w ? S_AXI_BRESP_O : S_AXI_RRESP_O;
      @(posedge CLK_I);
      S_AXI_AWVALID_I <= aw;
      S_AXI_WVALID_I <= wd;
      S_AXI_ARVALID_I <= ar;
      S_AXI_BREADY_I <= w && !dn;
      S_AXI_RREADY_I <= !w && !dn;
      n++;
      if (n > 60) tmo();
    end
  endtask : bus
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    bus(0, a, 0);
    chk(nm, e, q);
  endtask : rdc
  task automatic cmd(input logic [4:0] c);
    int n;
    n = 0;
    do begin
      @(negedge CLK_I);
      n++;
    end while (BUSY_O !== 1'b0 && n < 40);
    if (n >= 40) tmo();
    @(posedge CLK_I);
    {POPAF_I, PUSHAF_I, RETI_I, DISGINT_I, ENGINT_I} <= c;
    @(posedge CLK_I);
    {POPAF_I, PUSHAF_I, RETI_I, DISGINT_I, ENGINT_I} <= 5'h00;
  endtask : cmd
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(negedge CLK_I);
      n++;
    end while (LOAD_PC_O !== 1'b1 && RESTORE_AF_O !== 1'b1 && n < 40);
    if (n >= 40) tmo();
  endtask : wt
  always @(posedge CLK_I) begin
    st_lf <= nx(st_lf);
    stall <= st_lf[0] & st_lf[1];
    if (TAKE_O === 1'b1) begin
      saved_pc <= PC_I;
      takes <= takes + 1;
    end
  end
  initial begin
    CLK_I = 0;
    forever #20 CLK_I = ~CLK_I;
  end
  initial begin
    {RESET_N_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} = 4'h0;
    {S_AXI_ARVALID_I, S_AXI_RREADY_I, ENGINT_I, DISGINT_I, RETI_I} = 5'h00;
    {PUSHAF_I, POPAF_I, IRQ_SRC_I, ACC_I, FLAGS_I} = 24'h0;
    {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I} = 56'h0;
    S_AXI_WSTRB_I = 4'hf;
    rv = 16'h0e81;
    repeat (10) @(posedge CLK_I);
    RESET_N_I <= 1;
    rdc(`IERC_OFF_EN, 0, "en reset");
    rdc(`IERC_OFF_RQ, 0, "flags reset");
    rdc(`IERC_OFF_EDGE, 0, "edge reset");
    rdc(`IERC_OFF_SP, 0, "sp reset");
    rdc(`IERC_OFF_STAT, ierc_pkg::ST_IDLE, "state reset");
    rdc(12'h014, 0, "unmapped data");
    chk("unmapped resp", 2'h2, rsp);
    bus(1, 12'h014, 0);
    chk("unmapped wresp", 2'h2, rsp);
    bus(1, `IERC_OFF_STAT, 0);
    chk("status wresp", 0, rsp);
    rdc(`IERC_OFF_STAT, ierc_pkg::ST_IDLE, "status kept");
    for (int m = 0; m < 4; m++) begin
      bus(1, `IERC_OFF_EDGE, {20'h0, {6{m[1:0]}}});
      bus(1, `IERC_OFF_RQ, 0);
      IRQ_SRC_I <= 6'h3f;
      repeat (8) @(posedge CLK_I);
      rdc(`IERC_OFF_RQ, {26'h0, {6{exp_edge(m, 1)}}}, "rise flags");
      bus(1, `IERC_OFF_RQ, 0);
      IRQ_SRC_I <= 6'h00;
      repeat (8) @(posedge CLK_I);
      rdc(`IERC_OFF_RQ, {26'h0, {6{exp_edge(m, 0)}}}, "fall flags");
    end
    bus(1, `IERC_OFF_EDGE, 0);
    IRQ_SRC_I <= 6'h3f;
    repeat (8) @(posedge CLK_I);
    ex = 6'h3f;
    for (int i = 0; i < 3; i++) begin
      rv = nx(rv);
      ex &= rv[5:0];
      bus(1, `IERC_OFF_RQ, {26'h0, rv[5:0]});
      rdc(`IERC_OFF_RQ, ex, "clear flags");
    end
    IRQ_SRC_I <= 6'h00;
    bus(1, `IERC_OFF_RQ, 0);
    rv = nx(rv);
    sp = rv[7:0] & 8'h7e;
    k = rv[10:8] % 6;
    j = (k + 1) % 6;
    bus(1, `IERC_OFF_SP, sp);
    chk("sp wresp", 0, rsp);
    bus(1, `IERC_OFF_EN, 1 << k);
    IRQ_SRC_I <= 6'(1 << j);
    cmd(5'h01);
    repeat (10) @(posedge CLK_I);
    chk("no take", 0, takes);
    IRQ_SRC_I <= 6'((1 << j) | (1 << k));
    wt();
    chk("vector", 16'h0010, NEW_PC_O);
    chk("gie entry", 0, GIE_O);
    chk("takes", 1, takes);
    rdc(`IERC_OFF_SP, sp + 8'h02, "sp entry");
    bus(1, `IERC_OFF_RQ, 0);
    IRQ_SRC_I <= 6'h00;
    cmd(5'h04);
    wt();
    chk("return pc", saved_pc, NEW_PC_O);
    chk("gie return", 1, GIE_O);
    rdc(`IERC_OFF_SP, sp, "sp return");
    rv = nx(rv);
    ACC_I <= rv[7:0];
    FLAGS_I <= rv[15:8];
    cmd(5'h08);
    ACC_I <= ~rv[7:0];
    FLAGS_I <= ~rv[15:8];
    cmd(5'h10);
    wt();
    chk("acc", rv[7:0], ACC_O);
    chk("flags", rv[15:8], FLAGS_O);
    cmd(5'h02);
    repeat (2) @(posedge CLK_I);
    chk("gie off", 0, GIE_O);
    print_verdict();
  end
endmodule : ierc_top_tb
`default_nettype wire
